/* rtl/servo_stop_and_zero_clamp.sv */
// Servo stop mode sequencer, control mode selection and zero clamp loop
module servo_stop_and_zero_clamp (
  // Clock and reset
  input  wire logic                                ref_clk,
  input  wire logic                                rst,
  // Configuration
  input  wire servo_stop_pkg::servo_cfg_s          cfg,
  // Contact pins, active low, asynchronous
  input  wire logic                                servo_on_n,
  input  wire logic                                zero_clamp_input_n,
  // Internal status from same clock
  input  wire logic                                servo_alarm,
  input  wire logic                                main_power_ok,
  input  wire logic                                motor_stopped,
  input  wire logic                                speed_very_low,
  // Speed reference, signed r/min, same clock
  input  wire logic signed [servo_stop_pkg::SPEED_W-1:0] speed_ref,
  // Reference offset adjustment
  input  wire logic                                offset_auto_start,
  input  wire logic                                offset_manual_load,
  input  wire logic signed [servo_stop_pkg::SPEED_W-1:0] offset_manual_value,
  // Reference pulses and feedback pulses
  input  wire logic                                ref_pulse,
  input  wire logic                                ref_pulse_dir,
  input  wire logic                                fb_pulse,
  input  wire logic                                fb_pulse_dir,
  // Outputs
  output servo_stop_pkg::ctrl_sel_s                ctrl_sel,
  output logic                                     drive_enable,
  output logic                                     dynamic_brake,
  output logic                                     servo_off,
  output logic signed [servo_stop_pkg::POS_W-1:0]  ref_pulse_count,
  output logic signed [servo_stop_pkg::POS_W-1:0]  clamp_error,
  output logic                                     clamp_fwd,
  output logic                                     clamp_rev,
  output logic signed [servo_stop_pkg::SPEED_W-1:0] ref_offset,
  output logic signed [servo_stop_pkg::SPEED_W-1:0] speed_ref_adj
);

  localparam int SW = servo_stop_pkg::SPEED_W;
  localparam int PW = servo_stop_pkg::POS_W;
  // Contact pins behind synchronisers
  localparam int NPIN = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, one generate loop for both contact pins
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_lvl;
  assign pin_raw = {zero_clamp_input_n, servo_on_n};

  // One filter per contact pin
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      input_sync u_sync (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .reset_level (1'b1),
        .pin_in      (pin_raw[gi]),
        .level_out   (pin_lvl[gi])
      );
    end
  endgenerate

  // Synchronised levels, low means on
  logic servo_on_req;
  logic contact_on;
  assign servo_on_req = ~pin_lvl[0];
  assign contact_on   = ~pin_lvl[1];

  ////////////////////////////////////////////////////////////////////////////
  // Offset adjustment and clamp level
  // Offset, adjusted reference and clamp level
  logic signed [SW-1:0] offset_reg;
  logic signed [SW-1:0] offset_next;
  logic signed [SW-1:0] adj_reg;
  logic signed [SW-1:0] adj_next;
  logic [SW-1:0]        ref_mag;
  logic [SW-1:0]        level_lim;
  logic [SW-1:0]        level_eff;
  logic                 ref_slow;

  // Auto cancels the present reference, manual loads the user value
  always_comb begin
    offset_next = offset_reg;
    if (offset_auto_start) begin
      offset_next = speed_ref;
    end else if (offset_manual_load) begin
      offset_next = offset_manual_value;
    end
    adj_next = speed_ref - offset_reg;
  end

  // Clamp level range limit, then cap at motor maximum speed
  always_comb begin
    level_lim = (cfg.clamp_level_setting > servo_stop_pkg::CLAMP_LEVEL_MAX)
              ? servo_stop_pkg::CLAMP_LEVEL_MAX
              : cfg.clamp_level_setting;
    level_eff = (level_lim > cfg.max_speed) ? cfg.max_speed
                                            : level_lim;
    ref_mag   = adj_reg[SW-1] ? SW'(-adj_reg) : adj_reg;
    // Reference magnitude below the effective level
    ref_slow  = ref_mag < level_eff;
  end

  // Offset and adjusted reference registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      offset_reg <= '0;
      adj_reg    <= '0;
    end else begin
      offset_reg <= offset_next;
      adj_reg    <= adj_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control mode selection
  // Registered selection, clamp condition, servo-off flag
  servo_stop_pkg::ctrl_sel_s sel_reg;
  servo_stop_pkg::ctrl_sel_s sel_next;
  logic                      clamp_cond;
  logic                      servo_off_reg;

  // Mode decode and clamp condition
  always_comb begin
    sel_next   = '0;
    clamp_cond = 1'b0;
    case (cfg.control_mode_setting)
      servo_stop_pkg::MODE_SPEED: begin
        sel_next.speed_mode = 1'b1;
        clamp_cond = cfg.zero_clamp_allocated & contact_on;
      end
      servo_stop_pkg::MODE_TRQ_SPD: begin
        sel_next.torque_mode = ~contact_on;
        sel_next.speed_mode  = contact_on;
      end
      servo_stop_pkg::MODE_SPD_CLAMP: begin
        sel_next.speed_mode = 1'b1;
        clamp_cond = contact_on;
      end
      servo_stop_pkg::MODE_POS_INHIB: begin
        sel_next.position_mode = 1'b1;
        sel_next.pulse_blocked = contact_on;
      end
      default: begin
        sel_next.speed_mode = 1'b1;
      end
    endcase
    // All conditions plus servo on
    sel_next.clamp_active = clamp_cond & ref_slow
                          & ~servo_off_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stop sequencer
  // State and registered outputs
  servo_stop_pkg::stop_state_e st_reg;
  servo_stop_pkg::stop_state_e st_next;
  logic servo_off_next;
  logic drive_reg;
  logic drive_next;
  logic db_reg;
  logic db_next;
  logic off_cause;

  // Next state and output levels
  always_comb begin
    // Any servo-off cause
    off_cause      = ~servo_on_req | servo_alarm | ~main_power_ok;
    st_next        = st_reg;
    case (st_reg)
      servo_stop_pkg::ST_RUN: begin
        if (off_cause) begin
          if (cfg.stop_mode_setting == servo_stop_pkg::STOP_COAST) begin
            st_next = servo_stop_pkg::ST_COAST;
          end else if (cfg.stop_mode_setting == servo_stop_pkg::STOP_DB_HOLD
                       && (motor_stopped | speed_very_low)) begin
            st_next = servo_stop_pkg::ST_COAST;
          end else begin
            st_next = servo_stop_pkg::ST_BRAKE;
          end
        end
      end
      servo_stop_pkg::ST_BRAKE: begin
        if (motor_stopped) begin
          st_next = servo_stop_pkg::ST_STOPPED;
        end
      end
      servo_stop_pkg::ST_STOPPED,
      servo_stop_pkg::ST_COAST: begin
        if (!off_cause) begin
          st_next = servo_stop_pkg::ST_RUN;
        end
      end
      default: begin
        st_next = servo_stop_pkg::ST_COAST;
      end
    endcase
    // Drive only in run, servo off otherwise
    servo_off_next = (st_next != servo_stop_pkg::ST_RUN);
    drive_next     = (st_next == servo_stop_pkg::ST_RUN);
    // Brake while stopping, and after stop only in hold mode
    db_next = (st_next == servo_stop_pkg::ST_BRAKE)
            | ((st_next == servo_stop_pkg::ST_STOPPED)
               & (cfg.stop_mode_setting
                  == servo_stop_pkg::STOP_DB_HOLD));
  end

  // Sequencer and selection registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg        <= servo_stop_pkg::ST_COAST;
      servo_off_reg <= 1'b1;
      drive_reg     <= 1'b0;
      db_reg        <= 1'b0;
      sel_reg       <= '0;
    end else begin
      st_reg        <= st_next;
      servo_off_reg <= servo_off_next;
      drive_reg     <= drive_next;
      db_reg        <= db_next;
      sel_reg       <= sel_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference pulse counter and zero clamp position loop
  // Count, error and drive flag state
  logic signed [PW-1:0] cnt_reg;
  logic signed [PW-1:0] cnt_next;
  logic signed [PW-1:0] err_reg;
  logic signed [PW-1:0] err_next;
  logic                 fwd_reg;
  logic                 fwd_next;
  logic                 rev_reg;
  logic                 rev_next;

  // Pulse count and clamp error next values
  always_comb begin
    cnt_next = cnt_reg;
    if (ref_pulse && sel_reg.position_mode && !sel_reg.pulse_blocked) begin
      cnt_next = ref_pulse_dir ? cnt_reg - PW'(1)
                               : cnt_reg + PW'(1);
    end
    // Error held from clamp entry; feedback moves it
    err_next = '0;
    if (sel_reg.clamp_active) begin
      err_next = err_reg;
      if (fb_pulse) begin
        err_next = fb_pulse_dir ? err_reg - PW'(1)
                                : err_reg + PW'(1);
      end
    end
    // Drive back whenever displaced by more than one pulse
    fwd_next = sel_reg.clamp_active & (err_next < -PW'(1));
    rev_next = sel_reg.clamp_active & (err_next > PW'(1));
  end

  // Counter and clamp loop registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_reg <= '0;
      err_reg <= '0;
      fwd_reg <= 1'b0;
      rev_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      err_reg <= err_next;
      fwd_reg <= fwd_next;
      rev_reg <= rev_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  assign ctrl_sel        = sel_reg;
  assign drive_enable    = drive_reg;
  assign dynamic_brake   = db_reg;
  assign servo_off       = servo_off_reg;
  assign ref_pulse_count = cnt_reg;
  assign clamp_error     = err_reg;
  assign clamp_fwd       = fwd_reg;
  assign clamp_rev       = rev_reg;
  assign ref_offset      = offset_reg;
  assign speed_ref_adj   = adj_reg;

endmodule

/* rtl/servo_stop_pkg.sv */
// Package of constants and types for the servo stop and zero clamp block
package servo_stop_pkg;

  // Control mode setting codes
  localparam logic [3:0] MODE_SPEED      = 4'h0;
  localparam logic [3:0] MODE_TRQ_SPD    = 4'h9;
  localparam logic [3:0] MODE_SPD_CLAMP  = 4'ha;
  localparam logic [3:0] MODE_POS_INHIB  = 4'hb;

  // Stop mode setting codes
  localparam logic [1:0] STOP_DB_HOLD    = 2'h0;
  localparam logic [1:0] STOP_DB_RELEASE = 2'h1;
  localparam logic [1:0] STOP_COAST      = 2'h2;

  // Clamp level limits and reset default, r/min
  localparam logic [15:0] CLAMP_LEVEL_MAX = 16'h2710;
  localparam logic [15:0] CLAMP_LEVEL_DEF = 16'h000a;

  // Widths
  localparam int SPEED_W = 16;
  localparam int POS_W   = 32;

  // Stop sequencer states, Gray coded along run, braking, stopped
  typedef enum logic [1:0] {
    ST_RUN     = 2'b00,
    ST_BRAKE   = 2'b01,
    ST_STOPPED = 2'b11,
    ST_COAST   = 2'b10
  } stop_state_e;

  // Configuration carried together
  typedef struct packed {
    logic [3:0]  control_mode_setting;
    logic [1:0]  stop_mode_setting;
    logic [15:0] clamp_level_setting;
    logic [15:0] max_speed;
    logic        zero_clamp_allocated;
  } servo_cfg_s;

  // Control mode result carried together
  typedef struct packed {
    logic speed_mode;
    logic torque_mode;
    logic position_mode;
    logic clamp_active;
    logic pulse_blocked;
  } ctrl_sel_s;

endpackage

/* rtl/input_sync.sv */
// Three flop synchroniser that accepts a change once stages two and three agree
module input_sync (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic reset_level,
  // Pin side
  input  wire logic pin_in,
  // Filtered level
  output logic      level_out
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  logic level_next;

  // Accept the new level only on agreement of stages two and three
  always_comb begin
    level_next = level_reg;
    if (s2_reg == s3_reg) begin
      level_next = s3_reg;
    end
  end

  // Registers only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_reg    <= reset_level;
      s2_reg    <= reset_level;
      s3_reg    <= reset_level;
      level_reg <= reset_level;
    end else begin
      s1_reg    <= pin_in;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign level_out = level_reg;

endmodule

/* verif/host_model.sv */
// Host and motor model driving the contact pins and the standstill flag
module host_model (
  // Clock
  input  wire logic ref_clk,
  // Requests from the bench
  input  wire logic on_req,
  input  wire logic clamp_req,
  input  wire logic still,
  // Drive state fed back
  input  wire logic drive_enable,
  // Pins and motor status
  output logic      servo_on_n,
  output logic      zero_clamp_input_n,
  output logic      motor_stopped
);
  timeunit 1ns;
  timeprecision 1ps;
  int coast_cnt = 0;
  // Contacts start released, active low
  initial begin
    servo_on_n = 1'b1;
    zero_clamp_input_n = 1'b1;
  end
  // Pins change just after the edge
  always @(posedge ref_clk) begin
    servo_on_n <= !on_req;
    zero_clamp_input_n <= !clamp_req;
    coast_cnt <= drive_enable ? 0 : coast_cnt + 1;
  end
  // Motor runs down twenty cycles after drive is cut
  assign motor_stopped = still || coast_cnt >= 20;
endmodule

/* verif/servo_stop_and_zero_clamp_assertions.sv */
// Port checker for the servo stop and zero clamp block
module servo_stop_and_zero_clamp_assertions (
  // Clock and reset
  input wire logic                       ref_clk,
  input wire logic                       rst,
  // Inputs watched
  input wire servo_stop_pkg::servo_cfg_s cfg,
  input wire logic                       servo_alarm,
  input wire logic                       motor_stopped,
  input wire logic                       speed_very_low,
  input wire logic                       ref_pulse,
  input wire logic                       ref_pulse_dir,
  // Outputs watched
  input wire servo_stop_pkg::ctrl_sel_s  ctrl_sel,
  input wire logic                       drive_enable,
  input wire logic                       dynamic_brake,
  input wire logic                       servo_off,
  input wire logic signed [31:0]         ref_pulse_count,
  input wire logic signed [31:0]         clamp_error,
  input wire logic                       clamp_fwd,
  input wire logic                       clamp_rev
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  // Stop sequencing
  property p_alarm_off;
    servo_alarm |-> ##[1:2] (servo_off && !drive_enable);
  endproperty
  a_alarm_off: assert property (p_alarm_off)
    else $error("alarm did not turn the servo off");
  property p_coast;
    $rose(servo_off) && cfg.stop_mode_setting == 2'h2 |-> !dynamic_brake [*2];
  endproperty
  a_coast: assert property (p_coast)
    else $error("brake engaged in coast mode");
  property p_hold;
    dynamic_brake && motor_stopped && cfg.stop_mode_setting == 2'h0
      |=> dynamic_brake || !servo_off;
  endproperty
  a_hold: assert property (p_hold)
    else $error("brake released after stop in hold mode");
  property p_release;
    dynamic_brake && motor_stopped && cfg.stop_mode_setting == 2'h1
      |=> !dynamic_brake;
  endproperty
  a_release: assert property (p_release)
    else $error("brake kept after stop in release mode");
  property p_low;
    $rose(servo_off) && cfg.stop_mode_setting == 2'h0
      && $past(motor_stopped || speed_very_low) |-> !dynamic_brake;
  endproperty
  a_low: assert property (p_low)
    else $error("brake used on a still motor");
  ////////////////////////////////////////////////////////////////////////
  // Pulse counting and clamp loop
  property p_count;
    ref_pulse && ctrl_sel.position_mode && !ctrl_sel.pulse_blocked
      |=> ref_pulse_count == $past(ref_pulse_count)
          + ($past(ref_pulse_dir) ? -32'sd1 : 32'sd1);
  endproperty
  a_count: assert property (p_count)
    else $error("accepted pulse miscounted");
  property p_block;
    ref_pulse && ctrl_sel.pulse_blocked |=> $stable(ref_pulse_count);
  endproperty
  a_block: assert property (p_block)
    else $error("blocked pulse counted");
  property p_loop;
    clamp_rev == (clamp_error > 32'sd1) && clamp_fwd == (clamp_error < -32'sd1);
  endproperty
  a_loop: assert property (p_loop)
    else $error("clamp drive does not match error");
  // Main scenarios reached
  c_held: cover property (dynamic_brake && motor_stopped);
  c_clamp: cover property (ctrl_sel.clamp_active && clamp_rev);
  c_block: cover property (ref_pulse && ctrl_sel.pulse_blocked);
endmodule

bind servo_stop_and_zero_clamp servo_stop_and_zero_clamp_assertions chk_u (
  .ref_clk, .rst, .cfg, .servo_alarm, .motor_stopped, .speed_very_low,
  .ref_pulse, .ref_pulse_dir, .ctrl_sel, .drive_enable, .dynamic_brake,
  .servo_off, .ref_pulse_count, .clamp_error, .clamp_fwd, .clamp_rev
);

/* verif/servo_stop_and_zero_clamp_test.sv */
// Self-checking bench for the servo stop and zero clamp block
module servo_stop_and_zero_clamp_test;
  timeunit 1ns;
  timeprecision 1ps;
  // Bench drives and design outputs
  logic ref_clk = 1'b0, rst = 1'b1, on_req = 1'b0, clamp_req = 1'b0;
  logic still = 1'b0, servo_alarm = 1'b0, main_power_ok = 1'b1;
  logic speed_very_low = 1'b0, offset_auto_start = 1'b0;
  logic offset_manual_load = 1'b0, ref_pulse = 1'b0, ref_pulse_dir = 1'b0;
  logic fb_pulse = 1'b0, fb_pulse_dir = 1'b0;
  logic signed [15:0] speed_ref = '0, offset_manual_value = '0;
  logic signed [15:0] ref_offset, speed_ref_adj;
  logic signed [31:0] ref_pulse_count, clamp_error;
  logic servo_on_n, zero_clamp_input_n, motor_stopped, drive_enable;
  logic dynamic_brake, servo_off, clamp_fwd, clamp_rev;
  servo_stop_pkg::servo_cfg_s cfg = '0;
  servo_stop_pkg::ctrl_sel_s  ctrl_sel;
  int mismatches = 0, tests_run = 0, cycles = 0;

  always #4 ref_clk = ~ref_clk;

  servo_stop_and_zero_clamp dut_u (.ref_clk, .rst, .cfg, .servo_on_n,
    .zero_clamp_input_n, .servo_alarm, .main_power_ok, .motor_stopped,
    .speed_very_low, .speed_ref, .offset_auto_start, .offset_manual_load,
    .offset_manual_value, .ref_pulse, .ref_pulse_dir, .fb_pulse,
    .fb_pulse_dir, .ctrl_sel, .drive_enable, .dynamic_brake, .servo_off,
    .ref_pulse_count, .clamp_error, .clamp_fwd, .clamp_rev, .ref_offset,
    .speed_ref_adj);
  host_model host_u (.ref_clk, .on_req, .clamp_req, .still, .drive_enable,
    .servo_on_n, .zero_clamp_input_n, .motor_stopped);

  ////////////////////////////////////////////////////////////////////////
  // Compare, wait, close
  task automatic chk(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic end_sim();
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Train of n reference or feedback pulses
  task automatic pulses(input logic fb, input logic d, input int n);
    @(posedge ref_clk);
    fb_pulse <= fb;
    ref_pulse <= !fb;
    fb_pulse_dir <= d;
    ref_pulse_dir <= d;
    repeat (n) @(posedge ref_clk);
    fb_pulse <= 1'b0;
    ref_pulse <= 1'b0;
    wt(1);
  endtask
  // Expected clamp state from mode, contact and reference
  function automatic logic exp_clamp(servo_stop_pkg::servo_cfg_s k,
                                     logic c, logic signed [15:0] r);
    logic [15:0] lim;
    lim = k.clamp_level_setting > 16'h2710 ? 16'h2710 : k.clamp_level_setting;
    if (k.max_speed < lim) lim = k.max_speed;
    return c && 16'(r < 0 ? -r : r) < lim && (k.control_mode_setting == 4'ha
      || (k.control_mode_setting == 4'h0 && k.zero_clamp_allocated));
  endfunction
  // Cut a hung run short
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    servo_stop_pkg::servo_cfg_s k;
    logic [3:0] md;
    logic c, d, e;
    logic signed [15:0] r, v;
    int n, expc;
    n = $urandom(7);
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    on_req <= 1'b1;
    wt(8);
    chk("drive_enable", drive_enable, 1);
    // Each stop mode paired with one servo-off cause
    for (int m = 0; m < 3; m++) begin
      @(posedge ref_clk);
      cfg.stop_mode_setting <= 2'(m);
      on_req <= m != 0;
      servo_alarm <= m == 1;
      main_power_ok <= m != 2;
      wt(8);
      chk("servo_off", servo_off, 1);
      chk("brake", dynamic_brake, m != 2);
      wt(40);
      chk("brake_after_stop", dynamic_brake, m == 0);
      @(posedge ref_clk);
      on_req <= 1'b1;
      servo_alarm <= 1'b0;
      main_power_ok <= 1'b1;
      wt(8);
      chk("drive_enable", drive_enable, 1);
    end
    // Hold mode on a still or creeping motor coasts
    for (int j = 0; j < 2; j++) begin
      @(posedge ref_clk);
      cfg.stop_mode_setting <= 2'h0;
      still <= j == 0;
      speed_very_low <= j == 1;
      on_req <= 1'b0;
      wt(8);
      chk("coast", dynamic_brake, 0);
      chk("coast_off", servo_off, 1);
      @(posedge ref_clk);
      on_req <= 1'b1;
      still <= 1'b0;
      speed_very_low <= 1'b0;
      wt(8);
    end
    // Modes in turn, random contacts, levels and references, edges first
    for (int i = 0; i < 40; i++) begin
      @(posedge ref_clk);
      md = (i % 4 == 0) ? 4'h0 : 4'h8 + 4'(i % 4);
      k = cfg;
      k.control_mode_setting = md;
      k.zero_clamp_allocated = 1'($urandom);
      k.clamp_level_setting = i < 4 ? 16'h2800 : 16'($urandom_range(0, 40));
      k.max_speed = i < 4 ? 16'hffff : 16'($urandom_range(0, 60));
      r = i < 4 ? 16'sh270e + 16'(i) : 16'($urandom_range(0, 60));
      if (i >= 4 && $urandom % 2 == 1) r = -r;
      c = 1'($urandom);
      cfg <= k;
      speed_ref <= r;
      clamp_req <= c;
      wt(8);
      chk("clamp", ctrl_sel.clamp_active, exp_clamp(k, c, r));
      chk("torque", ctrl_sel.torque_mode, md == 4'h9 && !c);
      chk("position", ctrl_sel.position_mode, md == 4'hb);
      e = md != 4'hb && !(md == 4'h9 && !c);
      chk("speed", ctrl_sel.speed_mode, e);
      chk("blocked", ctrl_sel.pulse_blocked, md == 4'hb && c);
    end
    // Clamp pushed one way then the other
    @(posedge ref_clk);
    cfg.control_mode_setting <= 4'ha;
    cfg.clamp_level_setting <= 16'h000a;
    cfg.max_speed <= 16'h0064;
    speed_ref <= '0;
    clamp_req <= 1'b1;
    wt(8);
    pulses(1'b1, 1'b0, 3);
    chk("clamp_error", clamp_error, 3);
    chk("clamp_rev", clamp_rev, 1);
    pulses(1'b1, 1'b1, 5);
    chk("clamp_error", clamp_error, -2);
    chk("clamp_fwd", clamp_fwd, 1);
    // Pulse counting with the inhibit contact at random
    expc = 0;
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      c = 1'($urandom);
      d = 1'($urandom);
      n = $urandom_range(1, 8);
      cfg.control_mode_setting <= 4'hb;
      clamp_req <= c;
      wt(8);
      pulses(1'b0, d, n);
      if (!c) expc += d ? -n : n;
      chk("pulse_count", ref_pulse_count, expc);
    end
    // Manual offset, then capture of the present reference
    r = 16'($urandom_range(0, 200)) - 16'sd100;
    v = 16'($urandom_range(0, 200)) - 16'sd100;
    @(posedge ref_clk);
    speed_ref <= r;
    offset_manual_value <= v;
    offset_manual_load <= 1'b1;
    @(posedge ref_clk);
    offset_manual_load <= 1'b0;
    wt(3);
    chk("ref_offset", ref_offset, v);
    chk("speed_ref_adj", speed_ref_adj, r - v);
    @(posedge ref_clk);
    offset_auto_start <= 1'b1;
    @(posedge ref_clk);
    offset_auto_start <= 1'b0;
    wt(3);
    chk("speed_ref_adj", speed_ref_adj, 0);
    chk("ref_offset", ref_offset, r);
    end_sim();
  end
endmodule
